// ===== rtl/event_data_pkg.sv
// What this block does
// - Copy the descriptor's 64-bit event data into the transfer event parameter.
// - Bits 31:22 of word two pick the interrupter; below interrupter_count.
// - With evaluate_next_flag set, evaluate the next descriptor before saving state.
// - With completion_interrupt_flag set, post an event and request an interrupt.
// - With event_interrupt_block_flag and completion_interrupt_flag set, post with irq_assert clear; irq_o rises from ST_POSTED if mask bit 0 is set.
// - A detected error condition writes its matching completion code.
// - Completion code zero is never reported as a real outcome.
// - Successful completion reports code one.
// - Data overrun or underrun reports code two.
// - Babble during the transaction reports code three.
// - No valid peripheral response reports code four.
// - An out-of-range or invalid descriptor parameter reports code five.
// - A stall condition reports code six.
// - Lacking resources for configuration or addressing reports code seven.
// - Lacking periodic bandwidth for configuration reports code eight.
`default_nettype none

package event_data_pkg;

  // ****************************************************************
  // Descriptor layout.
  // ****************************************************************
  localparam int EVAL_NEXT_BIT   = 1;
  localparam int CHAIN_BIT       = 4;
  localparam int COMPL_IRQ_BIT   = 5;
  localparam int IRQ_BLOCK_BIT   = 9;
  localparam int TYPE_LSB        = 10;
  localparam int TYPE_MSB        = 15;
  localparam int TARGET_LSB      = 22;
  localparam int TARGET_MSB      = 31;
  localparam int TARGET_W        = TARGET_MSB - TARGET_LSB + 1;

  typedef struct packed {
    logic [31:0] word3;
    logic [31:0] word2;
    logic [31:0] word1;
    logic [31:0] word0;
  } ring_descriptor_t;

  // ****************************************************************
  // Completion codes.
  // ****************************************************************
  localparam logic [7:0] CC_INVALID   = 8'h00;
  localparam logic [7:0] CC_SUCCESS   = 8'h01;
  localparam logic [7:0] CC_DATA_BUF  = 8'h02;
  localparam logic [7:0] CC_BABBLE    = 8'h03;
  localparam logic [7:0] CC_TXN       = 8'h04;
  localparam logic [7:0] CC_PARAM     = 8'h05;
  localparam logic [7:0] CC_STALL     = 8'h06;
  localparam logic [7:0] CC_RESOURCE  = 8'h07;
  localparam logic [7:0] CC_BANDWIDTH = 8'h08;

  typedef struct packed {
    logic data_buffer;
    logic babble;
    logic no_response;
    logic stall;
    logic resource;
    logic bandwidth;
  } error_cond_t;

  typedef struct packed {
    logic [63:0]         parameter_data;
    logic [7:0]          code;
    logic [TARGET_W-1:0] target;
    logic                irq_assert;
  } transfer_event_t;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ICOUNT  = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_MASK    = 8'h0c;
  localparam logic [7:0] OFS_LAST    = 8'h10;
  localparam logic [7:0] OFS_EVCNT   = 8'h14;

  localparam int         ICOUNT_W    = TARGET_W + 1;
  localparam logic [ICOUNT_W-1:0] ICOUNT_RST = 11'h001;
  localparam logic       CTRL_RST    = 1'b0;
  localparam int         STAT_W      = 4;
  localparam int         ST_POSTED   = 0;
  localparam int         ST_ERROR    = 1;
  localparam int         ST_PARAM    = 2;
  localparam int         ST_SAVED    = 3;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
  localparam int         LAST_TGT_LSB = 8;
  localparam int         LAST_CHAIN_BIT = 20;

endpackage : event_data_pkg

`default_nettype wire

// ===== rtl/event_data_completion.sv
`default_nettype none

module event_data_completion #(
  parameter logic [5:0] EVENT_DATA_TYPE = 6'h07  // Type code of the event data descriptor.
) (
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_n_i,
  input  wire logic                                   clk_en_i,
  input  wire logic                                   psel_i,
  input  wire logic                                   penable_i,
  input  wire logic                                   pwrite_i,
  input  wire logic [event_data_pkg::ADDR_W-1:0]      paddr_i,
  input  wire logic [31:0]                            pwdata_i,
  output logic                                        pready_o,
  output logic [31:0]                                 prdata_o,
  output logic                                        pslverr_o,
  input  wire logic                                   desc_valid_i,
  input  wire event_data_pkg::ring_descriptor_t       desc_i,
  input  wire event_data_pkg::error_cond_t            cond_i,
  output logic                                        desc_ready_o,
  output logic                                        event_valid_o,
  output event_data_pkg::transfer_event_t             event_o,
  input  wire logic                                   event_ready_i,
  output logic                                        save_state_o,
  output logic                                        irq_o
);

  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_POST} phase_t;

  phase_t                                  phase;
  logic                                    enable;
  logic [event_data_pkg::ICOUNT_W-1:0]     icount;
  logic [event_data_pkg::STAT_W-1:0]       status;
  logic [event_data_pkg::STAT_W-1:0]       mask;
  logic [31:0]                             evcnt;
  logic [7:0]                              last_code;
  logic [event_data_pkg::TARGET_W-1:0]     last_target;
  logic                                    last_chain;

  logic [63:0]                             hold_data;
  logic [event_data_pkg::TARGET_W-1:0]     hold_target;
  logic                                    hold_nxt;
  logic                                    hold_chain;
  logic                                    hold_irq;
  logic                                    hold_blk;
  logic                                    hold_type_ok;
  event_data_pkg::error_cond_t             hold_cond;

  // ****************************************************************
  // Completion code selection.
  // ****************************************************************
  function automatic logic [7:0] pick_code(input logic param_bad, input event_data_pkg::error_cond_t c);
    logic [7:0] code;
    code = event_data_pkg::CC_SUCCESS;
    if (param_bad)          code = event_data_pkg::CC_PARAM;
    else if (c.stall)       code = event_data_pkg::CC_STALL;
    else if (c.babble)      code = event_data_pkg::CC_BABBLE;
    else if (c.no_response) code = event_data_pkg::CC_TXN;
    else if (c.data_buffer) code = event_data_pkg::CC_DATA_BUF;
    else if (c.resource)    code = event_data_pkg::CC_RESOURCE;
    else if (c.bandwidth)   code = event_data_pkg::CC_BANDWIDTH;
    return code;
  endfunction : pick_code

  // ****************************************************************
  // Descriptor decode.
  // ****************************************************************
  // Only the named fields are picked out; reserved-zero bits never reach any logic.
  wire logic [63:0] in_data = {desc_i.word1, desc_i.word0};
  wire logic [event_data_pkg::TARGET_W-1:0] in_target =
    desc_i.word2[event_data_pkg::TARGET_MSB:event_data_pkg::TARGET_LSB];
  wire logic [5:0] in_type = desc_i.word3[event_data_pkg::TYPE_MSB:event_data_pkg::TYPE_LSB];
  wire logic take      = desc_valid_i & desc_ready_o;
  wire logic target_ok = {1'b0, hold_target} < icount;
  wire logic param_bad = ~target_ok | ~hold_type_ok;
  wire logic [7:0] code_now = pick_code(param_bad, hold_cond);
  wire logic need_event = hold_irq | (code_now != event_data_pkg::CC_SUCCESS);
  wire logic in_check  = (phase == ST_CHECK);
  wire logic posted    = (phase == ST_POST) & event_valid_o & event_ready_i;
  wire logic finish    = (in_check & ~need_event) | posted;
  wire logic save_now  = finish & ~hold_nxt;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire logic access   = psel_i & penable_i;
  wire logic first_ac = access & ~pready_o;
  wire logic wr_fire  = access & pready_o & pwrite_i;
  wire logic sel_ctrl   = (paddr_i == event_data_pkg::OFS_CTRL);
  wire logic sel_icount = (paddr_i == event_data_pkg::OFS_ICOUNT);
  wire logic sel_status = (paddr_i == event_data_pkg::OFS_STATUS);
  wire logic sel_mask   = (paddr_i == event_data_pkg::OFS_MASK);
  wire logic sel_last   = (paddr_i == event_data_pkg::OFS_LAST);
  wire logic sel_evcnt  = (paddr_i == event_data_pkg::OFS_EVCNT);
  wire logic hit = sel_ctrl | sel_icount | sel_status | sel_mask | sel_last | sel_evcnt;

  wire logic [31:0] last_word = {11'h000, last_chain, 2'h0, last_target, last_code};
  wire logic [31:0] rd_mux =
    sel_ctrl   ? {31'h0000_0000, enable} :
    sel_icount ? {21'h00_0000, icount} :
    sel_status ? {28'h000_0000, status} :
    sel_mask   ? {28'h000_0000, mask} :
    sel_last   ? last_word :
    sel_evcnt  ? evcnt : 32'h0000_0000;

  wire logic [event_data_pkg::STAT_W-1:0] stat_set = {
    save_now,
    finish & param_bad,
    finish & (code_now != event_data_pkg::CC_SUCCESS),
    posted};
  wire logic [event_data_pkg::STAT_W-1:0] stat_clr =
    (wr_fire & sel_status) ? pwdata_i[event_data_pkg::STAT_W-1:0] : 4'h0;
  // A hardware set in the same cycle as a software clear is kept.
  wire logic [event_data_pkg::STAT_W-1:0] next_status = (status & ~stat_clr) | stat_set;

  // ****************************************************************
  // Bus slave and register file.
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      enable    <= event_data_pkg::CTRL_RST;
      icount    <= event_data_pkg::ICOUNT_RST;
      mask      <= event_data_pkg::STAT_RST;
    end else if (clk_en_i) begin
      pready_o  <= first_ac;
      pslverr_o <= first_ac & ~hit;
      if (first_ac) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
      if (wr_fire & sel_ctrl) begin
        enable <= pwdata_i[0];
      end
      if (wr_fire & sel_icount) begin
        icount <= pwdata_i[event_data_pkg::ICOUNT_W-1:0];
      end
      if (wr_fire & sel_mask) begin
        mask <= pwdata_i[event_data_pkg::STAT_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Interrupt status.
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      status <= event_data_pkg::STAT_RST;
      irq_o  <= 1'b0;
    end else if (clk_en_i) begin
      status <= next_status;
      irq_o  <= |(next_status & mask);
    end
  end

  // ****************************************************************
  // Descriptor capture.
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hold_data    <= 64'h0000_0000_0000_0000;
      hold_target  <= '0;
      hold_nxt     <= 1'b0;
      hold_chain   <= 1'b0;
      hold_irq     <= 1'b0;
      hold_blk     <= 1'b0;
      hold_type_ok <= 1'b0;
      hold_cond    <= '0;
    end else if (clk_en_i && take) begin
      hold_data    <= in_data;
      hold_target  <= in_target;
      hold_nxt     <= desc_i.word3[event_data_pkg::EVAL_NEXT_BIT];
      hold_chain   <= desc_i.word3[event_data_pkg::CHAIN_BIT];
      hold_irq     <= desc_i.word3[event_data_pkg::COMPL_IRQ_BIT];
      hold_blk     <= desc_i.word3[event_data_pkg::IRQ_BLOCK_BIT];
      hold_type_ok <= (in_type == EVENT_DATA_TYPE);
      hold_cond    <= cond_i;
    end
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      phase         <= ST_IDLE;
      desc_ready_o  <= 1'b0;
      event_valid_o <= 1'b0;
      event_o       <= '0;
      save_state_o  <= 1'b0;
    end else if (clk_en_i) begin
      save_state_o <= save_now;
      case (phase)
        ST_IDLE: begin
          if (take) begin
            desc_ready_o <= 1'b0;
            phase        <= ST_CHECK;
          end else begin
            desc_ready_o <= enable;
          end
        end
        ST_CHECK: begin
          if (need_event) begin
            event_valid_o            <= 1'b1;
            event_o.parameter_data   <= hold_data;
            event_o.code             <= code_now;
            event_o.target           <= hold_target;
            event_o.irq_assert       <= ~(hold_irq & hold_blk);
            phase                    <= ST_POST;
          end else begin
            desc_ready_o <= enable;
            phase        <= ST_IDLE;
          end
        end
        ST_POST: begin
          if (event_ready_i) begin
            event_valid_o <= 1'b0;
            desc_ready_o  <= enable;
            phase         <= ST_IDLE;
          end
        end
        default: begin
          phase <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Completion record and event counter.
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      evcnt       <= 32'h0000_0000;
      last_code   <= event_data_pkg::CC_INVALID;
      last_target <= '0;
      last_chain  <= 1'b0;
    end else if (clk_en_i) begin
      if (posted) begin
        evcnt <= evcnt + 32'h0000_0001;
      end
      if (finish) begin
        last_code   <= code_now;
        last_target <= hold_target;
        last_chain  <= hold_chain;
      end
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  event_data_copy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && in_check && need_event |=> event_valid_o && event_o.parameter_data == hold_data)
    else $error("event parameter does not match descriptor data");

  target_route_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    event_valid_o && {1'b0, event_o.target} >= icount |-> event_o.code == event_data_pkg::CC_PARAM)
    else $error("out-of-range interrupter not flagged");

  save_defer_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && finish && hold_nxt |=> !save_state_o)
    else $error("state saved before next descriptor was evaluated");

  irq_post_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && in_check && hold_irq |=> event_valid_o)
    else $error("completion interrupt flag did not post an event");

  irq_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    event_valid_o && hold_irq && hold_blk |-> !event_o.irq_assert)
    else $error("blocked event still asserts an interrupt");

  code_nonzero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    event_valid_o |-> event_o.code != event_data_pkg::CC_INVALID)
    else $error("completion code zero reported");

  success_code_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && in_check && !param_bad && hold_cond == '0 && hold_irq
    |=> event_o.code == event_data_pkg::CC_SUCCESS)
    else $error("clean completion not reported as success");

  stall_code_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && in_check && !param_bad && hold_cond.stall |=> event_o.code == event_data_pkg::CC_STALL)
    else $error("stall not reported");

  error_event_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && in_check && hold_cond != '0 |=> event_valid_o && event_o.code != event_data_pkg::CC_SUCCESS)
    else $error("error condition completed without its code");

  hold_stable_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    event_valid_o && !event_ready_i && clk_en_i |=> event_valid_o && $stable(event_o))
    else $error("pending event changed before it was taken");

endmodule : event_data_completion

`default_nettype wire

// ===== verif/ring_software_model.sv
`default_nettype none

module ring_software_model (
  input  wire logic                             sys_clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             start_i,
  input  wire logic [3:0]                       delay_i,
  input  wire event_data_pkg::ring_descriptor_t desc_in_i,
  input  wire event_data_pkg::error_cond_t      cond_in_i,
  input  wire logic                             desc_ready_i,
  input  wire logic                             event_valid_i,
  output logic                                  desc_valid_o,
  output event_data_pkg::ring_descriptor_t      desc_o,
  output event_data_pkg::error_cond_t           cond_o,
  output logic                                  event_ready_o,
  output logic                                  taken_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_cnt;

  // ****************************************************************
  // Offer one descriptor, then consume its event after a delay.
  // ****************************************************************
  // Once taken, the descriptor lines show the inverse of their last value.
  always_ff @(posedge sys_clk_i) begin
    taken_o <= 1'b0;
    if (!rst_n_i) begin
      desc_valid_o  <= 1'b0;
      desc_o        <= '1;
      cond_o        <= '1;
      event_ready_o <= 1'b0;
      wait_cnt      <= 4'h0;
    end else begin
      if (desc_valid_o && desc_ready_i) begin
        desc_valid_o <= 1'b0;
        desc_o       <= ~desc_o;
        cond_o       <= ~cond_o;
        taken_o      <= 1'b1;
      end else if (start_i) begin
        desc_valid_o <= 1'b1;
        desc_o       <= desc_in_i;
        cond_o       <= cond_in_i;
      end
      if (event_valid_i && !event_ready_o) begin
        if (wait_cnt == delay_i) begin
          event_ready_o <= 1'b1;
          wait_cnt      <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        event_ready_o <= 1'b0;
      end
    end
  end

endmodule : ring_software_model

`default_nettype wire

// ===== verif/event_data_descriptor_completion_test.sv
`default_nettype none

module event_data_descriptor_completion_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] EV_TYPE = 6'h07;

  logic                                  sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                            paddr;
  logic [31:0]                           pwdata, prdata;
  logic                                  desc_valid, desc_ready, event_valid, event_ready;
  logic                                  save_state, irq, start, taken;
  logic [3:0]                            delay;
  event_data_pkg::ring_descriptor_t      desc, sw_desc;
  event_data_pkg::error_cond_t           cond, sw_cond;
  event_data_pkg::transfer_event_t       event_s, ev_cap;
  int                                    failures, total_checks, ev_cnt, save_cnt;

  event_data_completion #(.EVENT_DATA_TYPE(EV_TYPE)) i_dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .desc_valid_i(desc_valid), .desc_i(desc), .cond_i(cond),
    .desc_ready_o(desc_ready), .event_valid_o(event_valid), .event_o(event_s),
    .event_ready_i(event_ready), .save_state_o(save_state), .irq_o(irq));

  ring_software_model i_sw (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .start_i(start), .delay_i(delay), .desc_in_i(sw_desc),
    .cond_in_i(sw_cond), .desc_ready_i(desc_ready), .event_valid_i(event_valid),
    .desc_valid_o(desc_valid), .desc_o(desc), .cond_o(cond), .event_ready_o(event_ready), .taken_o(taken));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (event_valid === 1'b1 && event_ready === 1'b1) begin
      ev_cnt++;
      ev_cap = event_s;
    end
    if (save_state === 1'b1) save_cnt++;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic test_done;
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(64'({e, r}), 64'(exp));
  endtask : reg_chk

  // The flags nibble is {interrupt block, completion interrupt, chain, evaluate next}.
  function automatic event_data_pkg::ring_descriptor_t mk(input logic [63:0] data, input logic [9:0] tgt,
                                                           input logic [3:0] fl, input logic [5:0] ty);
    event_data_pkg::ring_descriptor_t d;
    d = '0;
    {d.word1, d.word0} = data;
    d.word2[31:22] = tgt;
    d.word3[15:10] = ty;
    d.word3[9] = fl[3];
    d.word3[5] = fl[2];
    d.word3[4] = fl[1];
    d.word3[1] = fl[0];
    return d;
  endfunction : mk

  // The low nibble of the data sets how long the consumer stalls the event.
  task automatic run(input event_data_pkg::ring_descriptor_t d, input event_data_pkg::error_cond_t c,
                     input logic ev, input logic [7:0] code, input logic ia, input int sv);
    int n, ev0, sv0;
    ev0 = ev_cnt;
    sv0 = save_cnt;
    @(posedge sys_clk);
    start   <= 1'b1;
    sw_desc <= d;
    sw_cond <= c;
    delay   <= d.word0[3:0];
    @(posedge sys_clk);
    start <= 1'b0;
    n = 0;
    while (taken !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    while (desc_ready !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 60) begin
      failures++;
      test_done();
    end
    repeat (2) @(posedge sys_clk);
    check(64'(ev_cnt - ev0), 64'(ev));
    if (ev) begin
      check(ev_cap.parameter_data, {d.word1, d.word0});
      check(64'(ev_cap.code), 64'(code));
      check(64'(ev_cap.target), 64'(d.word2[31:22]));
      check(64'(ev_cap.irq_assert), 64'(ia));
    end
    check(64'(save_cnt - sv0), 64'(sv));
  endtask : run

  task automatic clear_status;
    reg_wr(event_data_pkg::OFS_STATUS, 32'hf);
    repeat (2) @(posedge sys_clk);
    check(64'(irq), 64'h0);
  endtask : clear_status

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic sc_reset;
    logic [31:0] r;
    logic        e;
    check(64'({desc_ready, event_valid, save_state, irq}), 64'h0);
    reg_chk(event_data_pkg::OFS_CTRL, 32'h0);
    reg_chk(event_data_pkg::OFS_ICOUNT, 32'h1);
    reg_chk(event_data_pkg::OFS_STATUS, 32'h0);
    reg_chk(event_data_pkg::OFS_MASK, 32'h0);
    apb(1'b0, 8'h18, 32'h0, r, e);
    check(64'({e, r}), 64'h1_0000_0000);
    reg_wr(event_data_pkg::OFS_ICOUNT, 32'h4);
    reg_chk(event_data_pkg::OFS_ICOUNT, 32'h4);
    reg_wr(event_data_pkg::OFS_MASK, 32'hf);
    check(64'(desc_ready), 64'h0);
    reg_wr(event_data_pkg::OFS_CTRL, 32'h1);
  endtask : sc_reset

  task automatic sc_success;
    run(mk(64'h0123_4567_89ab_cde3, 10'h3, 4'b0100, EV_TYPE), '0, 1'b1, 8'h01, 1'b1, 1);
    check(64'(irq), 64'h1);
    reg_chk(event_data_pkg::OFS_STATUS, 32'h9);
    clear_status();
    run(mk(64'hfedc_ba98_7654_3210, 10'h2, 4'b1100, EV_TYPE), '0, 1'b1, 8'h01, 1'b0, 1);
    clear_status();
    run(mk(64'h1, 10'h1, 4'b0000, EV_TYPE), '0, 1'b0, 8'h00, 1'b0, 1);
    reg_chk(event_data_pkg::OFS_LAST, 32'h0000_0101);
    reg_chk(event_data_pkg::OFS_EVCNT, 32'h2);
    clear_status();
  endtask : sc_success

  task automatic sc_errors;
    logic [7:0] codes [6] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08};
    for (int i = 0; i < 6; i++) begin
      run(mk(64'(i), 10'h0, 4'b0000, EV_TYPE), event_data_pkg::error_cond_t'(6'h20 >> i), 1'b1, codes[i], 1'b1,
          1);
    end
    run(mk(64'h2, 10'h1, 4'b0000, 6'h3f), '0, 1'b1, 8'h05, 1'b1, 1);
    run(mk(64'h3, 10'h1, 4'b0000, EV_TYPE), event_data_pkg::error_cond_t'(6'h14), 1'b1, 8'h06, 1'b1, 1);
    reg_chk(event_data_pkg::OFS_STATUS, 32'hf);
    clear_status();
  endtask : sc_errors

  task automatic sc_eval_next;
    run(mk(64'h1, 10'h1, 4'b0101, EV_TYPE), '0, 1'b1, 8'h01, 1'b1, 0);
    run(mk(64'h2, 10'h1, 4'b0100, EV_TYPE), '0, 1'b1, 8'h01, 1'b1, 1);
    clear_status();
  endtask : sc_eval_next

  task automatic sc_reserved_chain;
    event_data_pkg::ring_descriptor_t d;
    d = mk(64'h55aa_0000_0000_55a0, 10'h3, 4'b0110, EV_TYPE);
    d.word2[21:0] = 22'h3fffff;
    d.word3[3:2] = 2'b11;
    d.word3[8:6] = 3'b111;
    run(d, '0, 1'b1, 8'h01, 1'b1, 1);
    reg_chk(event_data_pkg::OFS_LAST, 32'h0010_0301);
    clear_status();
  endtask : sc_reserved_chain

  task automatic sc_mask;
    reg_wr(event_data_pkg::OFS_MASK, 32'h0);
    run(mk(64'h4, 10'h0, 4'b0100, EV_TYPE), '0, 1'b1, 8'h01, 1'b1, 1);
    check(64'(irq), 64'h0);
    reg_wr(event_data_pkg::OFS_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(64'(irq), 64'h1);
    clear_status();
  endtask : sc_mask

  initial begin
    {rst_n, psel, penable, pwrite, start} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    delay = 4'h0;
    sw_desc = '0;
    sw_cond = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    sc_reset();
    sc_success();
    sc_errors();
    sc_eval_next();
    sc_reserved_chain();
    sc_mask();
    test_done();
  end

endmodule : event_data_descriptor_completion_test

`default_nettype wire
